/* inc/sds_regs.svh */
/*
 constants of the step/dir microstep sequencer.
 assumes a 100 MHz system clock and step/dir pins from an outside controller.
*/
//
// Functional notes
// [R1] only a rising step edge moves the sequencer.
// [R2] step and direction pins are synchronised before use.
// [R3] controller keeps step rate under clk/2, full steps under clk/512.
// [R4] sine table of 1024 positions, one electrical turn, indexed by counter.
// [R5] direction 0 adds step width, direction 1 subtracts it.
// [R6] step width is 1 at finest resolution, doubling up to 256 full step.
// [R7] coarser resolution snaps counter to nearest valid position of new grid.
// [R8] full step uses positions 128, 384, 640, 896 with width 256.
// [R9] half step offset 64 width 128; quarter step offset 32 width 64.
// [R10] full-step positions give equal 0.71 currents; never zero or full entries.
// [R11] each step edge yields up to 256 interpolated 1/256 microsteps.
// [R12] microsteps timed by previous step period split into equal parts.
// [R13] periods beyond 2^20 clocks derive no interpolation timing.
// [R14] step interval beyond measurable limit raises a standstill event.
// [R15] standstill starts standby reduction only when power-down select is set.
// [R16] standstill flag set on detection, cleared on next step edge.
// [R17] new interval applies one step later; unsent microsteps are skipped.
// [R18] index active at zero point, coil b sine rising through zero.
// [R19] position counter wraps 1023 to 0 and 0 to 1023.
// [R20] period counter saturates instead of wrapping.
//
`ifndef SDS_REGS_SVH
`define SDS_REGS_SVH

`define SDS_POS_W 10
`define SDS_POS_ZERO 10'h000
`define SDS_POS_ONE 10'h001
`define SDS_QUARTER 10'h100
`define SDS_TAB_SIZE 1024
`define SDS_RES_W 4
`define SDS_RES_FINE 4'h0
`define SDS_RES_FULL 4'h8
`define SDS_PER_W 20
`define SDS_PER_ZERO 20'h00000
`define SDS_PER_ONE 20'h00001
`define SDS_PER_MAX 20'hfffff
`define SDS_CUR_W 9
`define SDS_CUR_ZERO 9'h000
`define SDS_CUR_PEAK 9'h0ff
`define SDS_AMP_REAL 255.0
`define SDS_TWO_PI 6.283185307179586
`define SDS_ROUND_REAL 0.5

`endif

/* inc/sds_pkg.sv */
/*
 types of the step/dir microstep sequencer.
 assumes sds_regs.svh for widths.
*/
`include "sds_regs.svh"

package sds_pkg;

    typedef logic [`SDS_POS_W-1:0] sds_pos_t;
    typedef logic [`SDS_RES_W-1:0] sds_res_t;
    typedef logic [`SDS_PER_W-1:0] sds_per_t;
    typedef logic signed [`SDS_CUR_W-1:0] sds_cur_t;

    typedef enum logic [2:0]
    {
        SDS_MODE_HOLD = 3'b001,
        SDS_MODE_INTERP = 3'b010,
        SDS_MODE_STILL = 3'b100
    } sds_mode_t;

endpackage

/* inc/sds_step_if.sv */
/*
 link between sequencer and interpolator.
 assumes both ends share one clock.
*/
`timescale 1ns/10ps

interface sds_step_if;
    logic step_evt;
    sds_pkg::sds_res_t res;
    logic tick;
    logic period_valid;
    logic stst_evt;

    modport seq
    (
        output step_evt,
        output res,
        input tick,
        input period_valid,
        input stst_evt
    );

    modport interp
    (
        input step_evt,
        input res,
        output tick,
        output period_valid,
        output stst_evt
    );
endinterface // sds_step_if

/* core/sds_interp.sv */
/*
 step period measurement, microstep tick timing and standstill detection.
 assumes step_evt is a one-cycle pulse on the same clock.
*/
`timescale 1ns/10ps
`include "sds_regs.svh"

module sds_interp
(
    input wire logic clock,
    input wire logic nrst,
    sds_step_if.interp ifc
);

    sds_pkg::sds_per_t per_cnt_r;
    sds_pkg::sds_per_t per_cnt_nxt;
    sds_pkg::sds_per_t last_per_r;
    sds_pkg::sds_per_t last_per_nxt;
    sds_pkg::sds_per_t gap_cnt_r;
    sds_pkg::sds_per_t gap_cnt_nxt;
    sds_pkg::sds_per_t interval;
    logic valid_r;
    logic valid_nxt;
    logic tick_r;
    logic tick_nxt;
    logic stst_r;
    logic stst_nxt;
    logic seen_r;
    logic seen_nxt;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        per_cnt_nxt = per_cnt_r;
        last_per_nxt = last_per_r;
        valid_nxt = valid_r;
        gap_cnt_nxt = gap_cnt_r;
        tick_nxt = 1'b0;
        stst_nxt = 1'b0;
        seen_nxt = seen_r;
        // interval per microstep: last period / width
        interval = last_per_r >> ifc.res; // [R12]
        if (interval == `SDS_PER_ZERO)
        begin
            interval = `SDS_PER_ONE;
        end
        if (per_cnt_r != `SDS_PER_MAX)
        begin
            per_cnt_nxt = per_cnt_r + `SDS_PER_ONE; // [R20]
        end
        if (ifc.step_evt)
        begin
            // period just ended becomes timing for the next step
            last_per_nxt = per_cnt_r; // [R17]
            valid_nxt = (per_cnt_r != `SDS_PER_MAX); // [R13]
            per_cnt_nxt = `SDS_PER_ZERO;
            gap_cnt_nxt = `SDS_PER_ZERO;
            seen_nxt = 1'b0;
        end
        else
        begin
            if (gap_cnt_r + `SDS_PER_ONE >= interval)
            begin
                gap_cnt_nxt = `SDS_PER_ZERO;
                tick_nxt = valid_r; // [R12]
            end
            else
            begin
                gap_cnt_nxt = gap_cnt_r + `SDS_PER_ONE;
            end
            if (per_cnt_r == `SDS_PER_MAX && !seen_r)
            begin
                stst_nxt = 1'b1; // [R14]
                seen_nxt = 1'b1;
                valid_nxt = 1'b0; // [R13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            per_cnt_r <= `SDS_PER_ZERO;
            last_per_r <= `SDS_PER_ZERO;
            gap_cnt_r <= `SDS_PER_ZERO;
            valid_r <= 1'b0;
            tick_r <= 1'b0;
            stst_r <= 1'b0;
            seen_r <= 1'b0;
        end
        else
        begin
            per_cnt_r <= per_cnt_nxt;
            last_per_r <= last_per_nxt;
            gap_cnt_r <= gap_cnt_nxt;
            valid_r <= valid_nxt;
            tick_r <= tick_nxt;
            stst_r <= stst_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign ifc.tick = tick_r;
    assign ifc.period_valid = valid_r;
    assign ifc.stst_evt = stst_r;

endmodule // sds_interp

/* core/sds_sequencer.sv */
/*
 step/dir front end, microstep sequencer, sine table and index output.
 assumes step, dir, resolution and power-down select arrive asynchronously.
*/
`timescale 1ns/10ps
`include "sds_regs.svh"

module sds_sequencer
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic step_pin,
    input wire logic dir_pin,
    input wire logic [`SDS_RES_W-1:0] res_sel,
    input wire logic power_down_select_pin,
    output logic [`SDS_POS_W-1:0] microstep_position_count,
    output logic signed [`SDS_CUR_W-1:0] coil_a_cur,
    output logic signed [`SDS_CUR_W-1:0] coil_b_cur,
    output logic index_out,
    output logic standstill_flag,
    output logic standby_req
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // step width in table positions for a resolution code
    function automatic sds_pkg::sds_pos_t step_width(input sds_pkg::sds_res_t res);
        step_width = `SDS_POS_ONE << res; // [R6]
    endfunction

    // codes above full step clamp to full step
    function automatic sds_pkg::sds_res_t res_clamp(input sds_pkg::sds_res_t res);
        res_clamp = (res > `SDS_RES_FULL) ? `SDS_RES_FULL : res; // [R6]
    endfunction

    // nearest grid position: clear low bits, add half a width
    function automatic sds_pkg::sds_pos_t snap_pos(input sds_pkg::sds_pos_t pos,
                                                   input sds_pkg::sds_res_t res);
        sds_pkg::sds_pos_t w;
        w = step_width(res);
        snap_pos = (pos & ~(w - `SDS_POS_ONE)) | (w >> 1); // [R7] [R8] [R9]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic step_s1_r;
    logic step_s2_r;
    logic step_s3_r;
    logic dir_s1_r;
    logic dir_s2_r;
    logic pdn_s1_r;
    logic pdn_s2_r;
    sds_pkg::sds_res_t res_s1_r;
    sds_pkg::sds_res_t res_s2_r;
    sds_pkg::sds_res_t res_s3_r;
    sds_pkg::sds_res_t res_r;
    sds_pkg::sds_res_t res_nxt;
    logic step_rise;
    logic res_settled;
    sds_pkg::sds_res_t res_req;

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            step_s1_r <= 1'b0;
            step_s2_r <= 1'b0;
            step_s3_r <= 1'b0;
            dir_s1_r <= 1'b0;
            dir_s2_r <= 1'b0;
            pdn_s1_r <= 1'b0;
            pdn_s2_r <= 1'b0;
            res_s1_r <= `SDS_RES_FINE;
            res_s2_r <= `SDS_RES_FINE;
            res_s3_r <= `SDS_RES_FINE;
        end
        else
        begin
            step_s1_r <= step_pin; // [R2]
            step_s2_r <= step_s1_r; // [R2]
            step_s3_r <= step_s2_r;
            dir_s1_r <= dir_pin; // [R2]
            dir_s2_r <= dir_s1_r; // [R2]
            pdn_s1_r <= power_down_select_pin;
            pdn_s2_r <= pdn_s1_r;
            res_s1_r <= res_sel;
            res_s2_r <= res_s1_r;
            res_s3_r <= res_s2_r;
        end
    end

    // rising edge only
    assign step_rise = step_s2_r & ~step_s3_r; // [R1]

    // multi-bit code: adopted only once two samples agree
    assign res_settled = (res_s2_r == res_s3_r);
    assign res_req = res_settled ? res_clamp(res_s2_r) : res_r; // [R6]

    ////////////////////////////////////////////////////////////////////////
    // resolution register

    always_comb
    begin
        res_nxt = res_req; // [R7]
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            res_r <= `SDS_RES_FINE;
        end
        else
        begin
            res_r <= res_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interpolator

    sds_step_if u_if ();

    assign u_if.step_evt = step_rise;
    assign u_if.res = res_r;

    sds_interp u_interp
    (
        .clock(clock),
        .nrst(nrst),
        .ifc(u_if)
    );

    ////////////////////////////////////////////////////////////////////////
    // sine table

    sds_pkg::sds_cur_t sine_tab [0:`SDS_TAB_SIZE-1];

    for (genvar gi = 0; gi < `SDS_TAB_SIZE; gi++)
    begin : g_tab
        localparam int TAB_VAL = $rtoi($floor(`SDS_AMP_REAL
            * $sin(`SDS_TWO_PI * gi / `SDS_TAB_SIZE) + `SDS_ROUND_REAL));
        assign sine_tab[gi] = `SDS_CUR_W'(TAB_VAL); // [R4] [R10]
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer state

    sds_pkg::sds_pos_t pos_r;
    sds_pkg::sds_pos_t pos_nxt;
    sds_pkg::sds_pos_t target_r;
    sds_pkg::sds_pos_t target_nxt;
    sds_pkg::sds_pos_t base;
    sds_pkg::sds_pos_t width;
    sds_pkg::sds_mode_t mode_r;
    sds_pkg::sds_mode_t mode_nxt;
    logic move_dn_r;
    logic move_dn_nxt;
    logic stst_r;
    logic stst_nxt;
    logic standby_r;
    logic standby_nxt;
    logic index_r;
    logic index_nxt;
    sds_pkg::sds_cur_t coil_a_r;
    sds_pkg::sds_cur_t coil_a_nxt;
    sds_pkg::sds_cur_t coil_b_r;
    sds_pkg::sds_cur_t coil_b_nxt;

    always_comb
    begin
        pos_nxt = pos_r;
        target_nxt = target_r;
        mode_nxt = mode_r;
        move_dn_nxt = move_dn_r;
        stst_nxt = stst_r;
        base = target_r;
        width = step_width(res_r);
        if (res_req > res_r)
        begin
            // coarser grid: settle on nearest valid position
            target_nxt = snap_pos(target_r, res_req); // [R7]
            pos_nxt = target_nxt; // [R7]
            mode_nxt = sds_pkg::SDS_MODE_HOLD;
        end
        else if (step_rise)
        begin
            // unsent microsteps of the last step are dropped
            pos_nxt = base; // [R17]
            move_dn_nxt = dir_s2_r;
            if (dir_s2_r)
            begin
                target_nxt = base - width; // [R5] [R19]
            end
            else
            begin
                target_nxt = base + width; // [R5] [R19]
            end
            stst_nxt = 1'b0; // [R16]
            if (u_if.period_valid && width != `SDS_POS_ONE)
            begin
                mode_nxt = sds_pkg::SDS_MODE_INTERP; // [R11]
            end
            else
            begin
                // no timing known or finest resolution: jump straight to the new position
                pos_nxt = target_nxt; // [R13]
                mode_nxt = sds_pkg::SDS_MODE_HOLD;
            end
        end
        else
        begin
            unique case (mode_r)
                sds_pkg::SDS_MODE_INTERP:
                begin
                    if (u_if.tick)
                    begin
                        // one 1/256 microstep per tick
                        if (move_dn_r)
                        begin
                            pos_nxt = pos_r - `SDS_POS_ONE; // [R11] [R19]
                        end
                        else
                        begin
                            pos_nxt = pos_r + `SDS_POS_ONE; // [R11] [R19]
                        end
                        if (pos_nxt == target_r)
                        begin
                            mode_nxt = sds_pkg::SDS_MODE_HOLD;
                        end
                    end
                end
                sds_pkg::SDS_MODE_HOLD:
                begin
                    pos_nxt = pos_r;
                end
                sds_pkg::SDS_MODE_STILL:
                begin
                    pos_nxt = pos_r;
                end
            endcase
        end
        if (u_if.stst_evt)
        begin
            // detection wins over a clearing step in the same cycle
            stst_nxt = 1'b1; // [R14] [R16]
            if (!step_rise && res_req <= res_r)
            begin
                pos_nxt = target_r;
                mode_nxt = sds_pkg::SDS_MODE_STILL;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            pos_r <= `SDS_POS_ZERO;
            target_r <= `SDS_POS_ZERO;
            mode_r <= sds_pkg::SDS_MODE_HOLD;
            move_dn_r <= 1'b0;
            stst_r <= 1'b0;
        end
        else
        begin
            pos_r <= pos_nxt;
            target_r <= target_nxt;
            mode_r <= mode_nxt;
            move_dn_r <= move_dn_nxt;
            stst_r <= stst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output registers

    always_comb
    begin
        standby_nxt = stst_nxt & pdn_s2_r; // [R15]
        index_nxt = (pos_nxt == `SDS_POS_ZERO); // [R18]
        coil_b_nxt = sine_tab[pos_nxt]; // [R4]
        coil_a_nxt = sine_tab[pos_nxt + `SDS_QUARTER]; // [R4] [R10]
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            standby_r <= 1'b0;
            index_r <= 1'b1;
            coil_a_r <= `SDS_CUR_PEAK;
            coil_b_r <= `SDS_CUR_ZERO;
        end
        else
        begin
            standby_r <= standby_nxt;
            index_r <= index_nxt;
            coil_a_r <= coil_a_nxt;
            coil_b_r <= coil_b_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign microstep_position_count = pos_r;
    assign coil_a_cur = coil_a_r;
    assign coil_b_cur = coil_b_r;
    assign index_out = index_r;
    assign standstill_flag = stst_r;
    assign standby_req = standby_r;

endmodule // sds_sequencer

/* tb/sds_sequencer_props.sv */
/*
 port checker of the step/dir microstep sequencer.
 assumes the bind below onto sds_sequencer and one clock domain.
*/
`timescale 1ns/10ps
`include "sds_regs.svh"

module sds_sequencer_props
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic step_pin,
    input wire logic dir_pin,
    input wire logic [`SDS_RES_W-1:0] res_sel,
    input wire logic power_down_select_pin,
    input wire logic [`SDS_POS_W-1:0] microstep_position_count,
    input wire logic signed [`SDS_CUR_W-1:0] coil_a_cur,
    input wire logic signed [`SDS_CUR_W-1:0] coil_b_cur,
    input wire logic index_out,
    input wire logic standstill_flag,
    input wire logic standby_req
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    chk_index_zero:
        assert property (index_out == (microstep_position_count == 10'h000))
        else $error("index not tied to position zero");
    chk_coil_zero:
        assert property (microstep_position_count == 10'h000 |-> coil_a_cur == 9'h0ff && coil_b_cur == 9'h000)
        else $error("coil currents wrong at position zero");
    chk_full_equal:
        assert property (microstep_position_count == 10'h080 |-> coil_a_cur == coil_b_cur && coil_a_cur == 9'h0b4)
        else $error("coil currents unequal at full step");
    chk_stby_no_pdn:
        assert property ((!power_down_select_pin)[*4] |-> !standby_req)
        else $error("standby without power-down select");
    chk_stby_needs_still:
        assert property (standby_req |-> standstill_flag)
        else $error("standby without standstill");
    chk_no_fall_move:
        assert property ((!step_pin && res_sel == 4'h0)[*6] |-> $stable(microstep_position_count))
        else $error("position moved without rising step");
    chk_step_sync:
        assert property ($rose(step_pin) && res_sel == 4'h0 |=> $stable(microstep_position_count)
            ##[1:4] $changed(microstep_position_count))
        else $error("step not taken through synchroniser");
    chk_reset_vals:
        assert property ($rose(nrst) |-> microstep_position_count == 10'h000 && !standstill_flag && !standby_req)
        else $error("wrong values after reset");
    ////////////////////////////////////////////////////////////////
    cover property (index_out ##1 !index_out);
    cover property (microstep_position_count == 10'h380);
    cover property ($rose(step_pin) && dir_pin);
endmodule // sds_sequencer_props

bind sds_sequencer sds_sequencer_props sds_sequencer_props_i
(
    .clock(clock), .nrst(nrst), .step_pin(step_pin), .dir_pin(dir_pin),
    .res_sel(res_sel), .power_down_select_pin(power_down_select_pin),
    .microstep_position_count(microstep_position_count),
    .coil_a_cur(coil_a_cur), .coil_b_cur(coil_b_cur), .index_out(index_out),
    .standstill_flag(standstill_flag), .standby_req(standby_req)
);

/* tb/sds_ctrl_model.sv */
/*
 motion controller model driving step and direction.
 assumes a free running system clock.
*/
`timescale 1ns/10ps

module sds_ctrl_model
(
    input wire logic clock,
    output logic step_pin,
    output logic dir_pin
);
    initial
    begin
        step_pin = 1'b0;
        dir_pin = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one step: direction settles, then high and low halves
    task automatic pulse(input logic d, input int half);
        @(posedge clock);
        #1 dir_pin = d;
        repeat (3) @(posedge clock);
        #1 step_pin = 1'b1;
        repeat ((half < 2) ? 2 : half) @(posedge clock);
        #1 step_pin = 1'b0;
        repeat ((half < 2) ? 2 : half) @(posedge clock);
        #1;
    endtask
endmodule // sds_ctrl_model

/* tb/tb_sds_sequencer.sv */
/*
 testbench of the step/dir microstep sequencer.
 assumes the controller model and the bound checker.
*/
`timescale 1ns/10ps
`include "sds_regs.svh"

module tb_sds_sequencer;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic step_pin;
    logic dir_pin;
    logic [`SDS_RES_W-1:0] res_sel = 4'h0;
    logic power_down_select_pin = 1'b0;
    logic [`SDS_POS_W-1:0] microstep_position_count;
    logic signed [`SDS_CUR_W-1:0] coil_a_cur;
    logic signed [`SDS_CUR_W-1:0] coil_b_cur;
    logic index_out;
    logic standstill_flag;
    logic standby_req;
    int errors = 0;
    int n_tests = 0;

    always #5 clock = ~clock;

    sds_ctrl_model sds_ctrl_model_i (.clock(clock), .step_pin(step_pin), .dir_pin(dir_pin));

    sds_sequencer sds_sequencer_i
    (
        .clock(clock), .nrst(nrst), .step_pin(step_pin), .dir_pin(dir_pin),
        .res_sel(res_sel), .power_down_select_pin(power_down_select_pin),
        .microstep_position_count(microstep_position_count),
        .coil_a_cur(coil_a_cur), .coil_b_cur(coil_b_cur), .index_out(index_out),
        .standstill_flag(standstill_flag), .standby_req(standby_req)
    );
    ////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic report_and_stop();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pos(input logic [`SDS_POS_W-1:0] got, input logic [`SDS_POS_W-1:0] exp);
        cmp({6'h00, got}, {6'h00, exp});
    endtask

    task automatic cmp_cur(input logic [`SDS_CUR_W-1:0] got, input logic [`SDS_CUR_W-1:0] exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask

    // bounded wait for a settled position
    task automatic wait_pos(input logic [`SDS_POS_W-1:0] exp);
        int i;
        i = 0;
        while (microstep_position_count !== exp && i < 3000)
        begin
            tick(1);
            i++;
        end
        cmp_pos(microstep_position_count, exp);
        if (i == 3000)
            report_and_stop();
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cmp_pos(microstep_position_count, 10'h000);
        cmp_cur(coil_a_cur, 9'h0ff);
        cmp_cur(coil_b_cur, 9'h000);
        cmp_bit(index_out, 1'b1);
        cmp_bit(standstill_flag, 1'b0);
    endtask

    task automatic t_fine();
        power_down_select_pin = 1'b1;
        sds_ctrl_model_i.pulse(1'b0, 20);
        cmp_pos(microstep_position_count, 10'h001);
        cmp_bit(index_out, 1'b0);
        cmp_cur(coil_b_cur, 9'h002);
        sds_ctrl_model_i.pulse(1'b1, 2);
        wait_pos(10'h000);
        sds_ctrl_model_i.pulse(1'b1, 2);
        wait_pos(10'h3ff);
        sds_ctrl_model_i.pulse(1'b0, 2);
        wait_pos(10'h000);
        cmp_bit(index_out, 1'b1);
        cmp_bit(standby_req, 1'b0);
    endtask

    task automatic t_coarse();
        logic [`SDS_POS_W-1:0] full_tab [4] = '{10'h080, 10'h180, 10'h280, 10'h380};
        logic [`SDS_CUR_W-1:0] exp_b [4] = '{9'h0b4, 9'h0b4, 9'h14c, 9'h14c};
        repeat (5) sds_ctrl_model_i.pulse(1'b0, 2);
        wait_pos(10'h005);
        res_sel = 4'h6;
        tick(8);
        cmp_pos(microstep_position_count, 10'h020);
        sds_ctrl_model_i.pulse(1'b0, 4);
        wait_pos(10'h060);
        res_sel = 4'h7;
        tick(8);
        cmp_pos(microstep_position_count, 10'h040);
        sds_ctrl_model_i.pulse(1'b1, 4);
        wait_pos(10'h3c0);
        res_sel = 4'h8;
        tick(8);
        cmp_pos(microstep_position_count, 10'h380);
        foreach (full_tab[k])
        begin
            sds_ctrl_model_i.pulse(1'b0, 4);
            wait_pos(full_tab[k]);
            cmp_cur(coil_a_cur * coil_b_cur > 0 ? coil_a_cur : -coil_a_cur, coil_b_cur);
            cmp_cur(coil_b_cur, exp_b[k]);
            cmp_bit(index_out, 1'b0);
        end
    endtask

    task automatic t_interp();
        logic [`SDS_POS_W-1:0] prev;
        int n;
        sds_ctrl_model_i.pulse(1'b0, 298);
        wait_pos(10'h080);
        n = 0;
        prev = microstep_position_count;
        fork
            sds_ctrl_model_i.pulse(1'b0, 298);
            for (int i = 0; i < 700; i++)
            begin
                tick(1);
                if (i == 300)
                    cmp_bit(microstep_position_count != 10'h180, 1'b1);
                n += (microstep_position_count != prev);
                prev = microstep_position_count;
            end
        join
        cmp_pos(10'(n), 10'h100);
        sds_ctrl_model_i.pulse(1'b0, 40);
        sds_ctrl_model_i.pulse(1'b0, 2);
        tick(6);
        cmp_bit((microstep_position_count - 10'h280) < 10'h010, 1'b1);
        wait_pos(10'h380);
        cmp_bit(standstill_flag, 1'b0);
        res_sel = 4'hf;
        tick(8);
        cmp_pos(microstep_position_count, 10'h380);
        sds_ctrl_model_i.pulse(1'b0, 2);
        wait_pos(10'h080);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        tick(3);
        nrst = 1'b1;
        tick(1);
        t_reset();
        t_fine();
        t_coarse();
        t_interp();
        report_and_stop();
    end
endmodule // tb_sds_sequencer
